// *** bench/larm_host_model.sv ***
/* Host processor model driving the register port.
   Assumes requests are taken on the rising edge of mclk. */
`timescale 1ns/1ps
module larm_host_model
    import larm_pkg::*;
(
    // Host port
    input wire logic mclk,
    output larm_req_t host_req
);
    initial host_req = '0;
    // One-cycle strobe, dropped at the following edge
    task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        host_req <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge mclk);
        host_req <= '0;
    endtask : xfer
    // Stretched wait, safe for every port mode
    task automatic reset_wait();
        repeat (2 * larm_sw_reset_cycles) @(posedge mclk);
    endtask : reset_wait
endmodule : larm_host_model

// *** bench/larm_regs_monitor.sv ***
/* Port checker for larm_regs.
   Assumes one clock, mclk, and the async low reset arst_n. */
`timescale 1ns/1ps
module larm_regs_monitor
    import larm_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Watched ports
    input wire larm_req_t host_req,
    input wire logic host_rvalid,
    input wire logic sw_reset_busy,
    input wire logic [7:0] analog_loopback,
    input wire logic irq,
    input wire larm_mon_route_t mon_route
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic [8:0] busy_cnt_reg;
    logic [7:0] lb_reg;
    logic take;
    assign take = clk_en && !sw_reset_busy && !host_req.wr;
    // ==========================================================
    // Helpers: busy length and loopback as seen by the route
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt_reg <= 9'h000;
            lb_reg <= 8'h00;
        end else begin
            busy_cnt_reg <= sw_reset_busy ? busy_cnt_reg + {8'h00, clk_en} : 9'h000;
            if (clk_en) begin
                lb_reg <= analog_loopback;
            end
        end
    end
    // ==========================================================
    // Properties
    chk_reset_start: assert property (clk_en && !sw_reset_busy && host_req.wr && host_req.addr == 8'h0a
        |=> sw_reset_busy) else $error("reset cycle did not start");
    chk_reset_length: assert property ($fell(sw_reset_busy) |-> busy_cnt_reg == larm_sw_reset_count)
        else $error("reset cycle length wrong");
    chk_busy_refuse: assert property (sw_reset_busy && host_req.rd |=> !host_rvalid)
        else $error("read answered during reset");
    chk_reset_clears: assert property (sw_reset_busy && $past(sw_reset_busy, 3) |-> mon_route == 5'h00 && !irq)
        else $error("state not cleared by reset");
    chk_read_answer: assert property (take && host_req.rd |=> host_rvalid)
        else $error("read not answered");
    chk_no_monitor: assert property (mon_route.channel == 3'h0 |-> !mon_route.rx_enable && !mon_route.tx_enable)
        else $error("channel zero routed");
    chk_route_excl: assert property (!(mon_route.rx_enable && mon_route.tx_enable))
        else $error("receiver and transmitter both routed");
    chk_tx_loopback: assert property (mon_route.tx_enable |-> !lb_reg[mon_route.channel])
        else $error("transmitter routed in loopback");
    cover property (take && host_req.rd ##1 host_rvalid);
    cover property ($fell(sw_reset_busy));
    cover property ($rose(irq));
endmodule : larm_regs_monitor

bind larm_regs larm_regs_monitor chk (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .host_req(host_req),
    .host_rvalid(host_rvalid), .sw_reset_busy(sw_reset_busy), .analog_loopback(analog_loopback),
    .irq(irq), .mon_route(mon_route));

// *** bench/line_alarm_irq_reset_monitor_regs_tb.sv ***
/* Self-checking bench for larm_regs.
   Assumes the host model and the bound port checker. */
`timescale 1ns/1ps
module line_alarm_irq_reset_monitor_regs_tb
    import larm_pkg::*;
;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] signal_loss = 8'h00;
    logic [7:0] driver_fault = 8'h00;
    logic [7:0] analog_loopback = 8'h00;
    larm_req_t host_req;
    logic [7:0] host_rdata;
    logic host_rvalid;
    logic sw_reset_busy;
    logic irq;
    larm_mon_route_t mon_route;
    logic [31:0] seed = 32'h211b5e7a;
    logic [7:0] exp_q[$];
    logic [7:0] offs[7] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h3f};
    int fails = 0;
    int total_checks = 0;
    always #2 mclk = ~mclk;
    larm_regs dut (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .host_req(host_req), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .sw_reset_busy(sw_reset_busy), .signal_loss(signal_loss),
        .driver_fault(driver_fault), .analog_loopback(analog_loopback), .irq(irq), .mon_route(mon_route));
    larm_host_model host (.mclk(mclk), .host_req(host_req));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    // ==========================================================
    // Read data against the oldest note
    always @(posedge mclk) begin
        if (host_rvalid === 1'b1) begin
            if (exp_q.size() > 0) begin
                check(host_rdata, exp_q.pop_front());
            end else begin
                check({7'h00, host_rvalid}, 8'h00);
            end
        end
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        foreach (offs[i]) rd(offs[i], 8'h00);
        wr(8'h08, 8'hff);
        wr(8'h3f, 8'hff);
        rd(8'h08, 8'h00);
        seed = lfsr(seed);
        wr(8'h07, seed[7:0]);
        rd(8'h07, seed[7:0]);
        wr(8'h07, 8'h00);
        clk_en <= 1'b0;
        wr(8'h07, 8'h55);
        clk_en <= 1'b1;
        rd(8'h07, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            @(posedge mclk);
            if (i == 0) signal_loss <= seed[7:0]; else driver_fault <= seed[7:0];
            repeat (2) @(posedge mclk);
            rd(8'h08 + 8'(i), seed[7:0]);
            check({7'h00, irq}, 8'h00);
            rd(8'h08 + 8'(i), 8'h00);
            wr(8'h06 + 8'(i), 8'h10);
            @(posedge mclk);
            if (i == 0) signal_loss[4] <= ~signal_loss[4]; else driver_fault[4] <= ~driver_fault[4];
            repeat (3) @(posedge mclk);
            check({7'h00, irq}, 8'h01);
            rd(8'h08 + 8'(i), 8'h10);
            repeat (3) @(posedge mclk);
            check({7'h00, irq}, 8'h00);
            wr(8'h06 + 8'(i), 8'h00);
        end
        $display("test flags done");
        for (int a = 0; a < 16; a++) begin
            seed = lfsr(seed);
            @(posedge mclk);
            analog_loopback <= seed[15:8];
            wr(8'h0b, {seed[7:4], 4'(a)});
            rd(8'h0b, {4'h0, 4'(a)});
            check({6'h00, mon_route.rx_enable, mon_route.tx_enable}, {6'h00, !a[3] && a[2:0] != 0,
                a[3] && a[2:0] != 0 && !seed[8 + a[2:0]]});
            check({5'h00, mon_route.channel}, {5'h00, a[2:0]});
        end
        $display("test monitor done");
        wr(8'h07, 8'hff);
        wr(8'h0b, 8'h03);
        wr(8'h0a, 8'h5a);
        @(posedge mclk);
        check({7'h00, sw_reset_busy}, 8'h01);
        wr(8'h0b, 8'h05);
        host.xfer(1'b0, 1'b1, 8'h07, 8'h00);
        host.reset_wait();
        foreach (offs[i]) rd(offs[i], 8'h00);
        check({3'h0, mon_route}, 8'h00);
        repeat (2) @(posedge mclk);
        check(8'(exp_q.size()), 8'h00);
        $display("test software reset done");
        complete_run();
    end
    // Generous bound; the tests need under 2000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        complete_run();
    end
endmodule : line_alarm_irq_reset_monitor_regs_tb

// *** hdl/larm_change_detect.sv ***
/*
 * Per-channel change flag: sets on any edge of a status input except while
 * sync_clear is high, cleared by a host read or by sync_clear. Assumes status is synchronous to mclk.
 */
`timescale 1ns/1ps
module larm_change_detect
    import larm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic sync_clear,
    // Status
    input wire logic [WIDTH-1:0] status,
    input wire logic read_clear,
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] last_reg;
    logic [WIDTH-1:0] last_next;
    logic [WIDTH-1:0] flag_reg;
    logic [WIDTH-1:0] flag_next;

    always_comb begin
        last_next = status;
        // Set wins over the read clear so a change on the read cycle is kept; sync_clear wins over set
        flag_next = (read_clear || sync_clear) ? '0 : flag_reg;
        flag_next = flag_next | (status ^ last_reg);
        if (sync_clear) begin
            flag_next = '0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            last_reg <= '0;
            flag_reg <= '0;
        end else if (clk_en) begin
            last_reg <= last_next;
            flag_reg <= flag_next;
        end
    end

    assign flags = flag_reg;
endmodule : larm_change_detect

// *** hdl/larm_pkg.sv ***
/*
 * Package for the line alarm, interrupt, software reset and monitor
 * register bank. Assumes an eight channel transceiver around it.
 */
package larm_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] larm_off_driver_fault_irq_enable = 8'h07;
    localparam logic [7:0] larm_off_signal_loss_change_status = 8'h08;
    localparam logic [7:0] larm_off_driver_fault_change_status = 8'h09;
    localparam logic [7:0] larm_off_software_reset = 8'h0a;
    localparam logic [7:0] larm_off_monitor_channel_select = 8'h0b;
    localparam logic [7:0] larm_off_signal_loss_irq_enable = 8'h06;
    // ==========================================================
    // Reset values and fields
    localparam logic [7:0] larm_rst_byte = 8'h00;
    localparam logic [3:0] larm_rst_monitor = 4'h0;
    localparam int larm_mon_top_bit = 3;
    // ==========================================================
    // Timing
    localparam int larm_clk_mhz = 250;
    localparam int larm_sw_reset_us = 1;
    localparam int larm_sw_reset_cycles = larm_sw_reset_us * larm_clk_mhz;
    localparam logic [8:0] larm_sw_reset_count = 9'(larm_sw_reset_cycles);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } larm_req_t;

    typedef struct packed {
        logic rx_enable;
        logic tx_enable;
        logic [2:0] channel;
    } larm_mon_route_t;

    typedef enum logic {larm_run, larm_in_reset} larm_state_t;
endpackage : larm_pkg

// *** hdl/larm_regs.sv ***
/*
 * Register bank: interrupt enables, change status, software reset
 * cycle and performance monitor routing. Assumes a synchronous host
 * port with single-cycle read and write strobes.
 */
`timescale 1ns/1ps
// Function
// RULE1: One writable driver-fault interrupt enable bit per channel 7 to 0.
// RULE2: Driver-fault interrupt enables reset to zero.
// RULE3: Loss-of-signal change bit sets on every receiver loss-of-signal change. The code drops changes that arrive during the software reset cycle.
// RULE4: Loss-of-signal change bits reset to zero and are read-only.
// RULE5: Driver-fault change bit sets on each driver-fault change; resets zero. The code drops changes that arrive during the software reset cycle.
// RULE6: Writing software reset returns all registers to defaults.
// RULE7: Software reset write starts a one microsecond reset cycle.
// RULE8: Host in non-multiplexed first bus style stretches reset to two microseconds. The code has no bus style input and always counts one microsecond.
// RULE9: Monitor select all zero means no performance monitoring.
// RULE10: Top bit clear selects receiver 1 to 7 by lower bits.
// RULE11: Top bit set selects transmitter; not during that channel's analog loopback.
// RULE12: One host read clears all loss-of-signal interrupts.
// RULE13: One host read clears all driver-fault interrupts.
// RULE14: Loss-of-signal enable bits enable receiver interrupts; reset zero.
// RULE15: Interrupt output high when any enabled change bit is set.
// RULE16: Reserved upper monitor bits ignore writes and read zero.
module larm_regs
    import larm_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Host port
    input wire larm_req_t host_req,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    output logic sw_reset_busy,
    // Line status
    input wire logic [CHANNELS-1:0] signal_loss,
    input wire logic [CHANNELS-1:0] driver_fault,
    input wire logic [CHANNELS-1:0] analog_loopback,
    // Outputs
    output logic irq,
    output larm_mon_route_t mon_route
);
    // ==========================================================
    // Software reset sequencer
    larm_state_t state_reg;
    larm_state_t state_next;
    logic [8:0] cnt_reg;
    logic [8:0] cnt_next;
    logic sw_clear;
    logic wr_ok;
    logic rd_ok;

    assign wr_ok = host_req.wr && (state_reg == larm_run);
    assign rd_ok = host_req.rd && (state_reg == larm_run);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        sw_clear = 1'b0;
        unique case (state_reg)
            larm_run: begin
                if (wr_ok && host_req.addr == larm_off_software_reset) begin // [RULE7]
                    state_next = larm_in_reset;
                    cnt_next = larm_sw_reset_count - 9'h001;
                end
            end
            larm_in_reset: begin
                sw_clear = 1'b1; // [RULE6]
                if (cnt_reg == 9'h000) begin
                    state_next = larm_run;
                end else begin
                    cnt_next = cnt_reg - 9'h001;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= larm_run;
            cnt_reg <= 9'h000;
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // ==========================================================
    // Writable registers
    logic [CHANNELS-1:0] dfie_reg;
    logic [CHANNELS-1:0] dfie_next;
    logic [CHANNELS-1:0] slie_reg;
    logic [CHANNELS-1:0] slie_next;
    logic [3:0] mon_reg;
    logic [3:0] mon_next;

    always_comb begin
        dfie_next = dfie_reg;
        slie_next = slie_reg;
        mon_next = mon_reg;
        if (sw_clear) begin // [RULE6]
            dfie_next = '0;
            slie_next = '0;
            mon_next = larm_rst_monitor;
        end else if (wr_ok) begin
            unique case (host_req.addr)
                larm_off_driver_fault_irq_enable: dfie_next = host_req.wdata[CHANNELS-1:0]; // [RULE1]
                larm_off_signal_loss_irq_enable: slie_next = host_req.wdata[CHANNELS-1:0]; // [RULE14]
                larm_off_monitor_channel_select: mon_next = host_req.wdata[3:0]; // [RULE16]
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dfie_reg <= '0; // [RULE2]
            slie_reg <= '0; // [RULE14]
            mon_reg <= larm_rst_monitor;
        end else if (clk_en) begin
            dfie_reg <= dfie_next;
            slie_reg <= slie_next;
            mon_reg <= mon_next;
        end
    end

    // ==========================================================
    // Change status
    logic [CHANNELS-1:0] sl_flags;
    logic [CHANNELS-1:0] df_flags;
    logic sl_read;
    logic df_read;

    assign sl_read = rd_ok && host_req.addr == larm_off_signal_loss_change_status; // [RULE12]
    assign df_read = rd_ok && host_req.addr == larm_off_driver_fault_change_status; // [RULE13]

    larm_change_detect #(.WIDTH(CHANNELS)) u_sl_change (
        .mclk(mclk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .sync_clear(sw_clear),
        .status(signal_loss),
        .read_clear(sl_read),
        .flags(sl_flags)
    ); // [RULE3] [RULE4]

    larm_change_detect #(.WIDTH(CHANNELS)) u_df_change (
        .mclk(mclk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .sync_clear(sw_clear),
        .status(driver_fault),
        .read_clear(df_read),
        .flags(df_flags)
    ); // [RULE5]

    // ==========================================================
    // Read data, interrupt and monitor routing
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic irq_reg;
    logic irq_next;
    logic busy_reg;
    logic busy_next;
    larm_mon_route_t route_reg;
    larm_mon_route_t route_next;

    always_comb begin
        rdata_next = larm_rst_byte;
        unique case (host_req.addr)
            larm_off_driver_fault_irq_enable: rdata_next = 8'(dfie_reg);
            larm_off_signal_loss_irq_enable: rdata_next = 8'(slie_reg);
            larm_off_signal_loss_change_status: rdata_next = 8'(sl_flags);
            larm_off_driver_fault_change_status: rdata_next = 8'(df_flags);
            larm_off_monitor_channel_select: rdata_next = {4'h0, mon_reg}; // [RULE16]
            default: rdata_next = larm_rst_byte;
        endcase
        // Idle read data stays zero so a stale byte never looks valid
        if (!rd_ok) begin
            rdata_next = larm_rst_byte;
        end
        rvalid_next = rd_ok;
        // Busy follows the next state so it rises with the taking edge
        busy_next = (state_next == larm_in_reset);
        irq_next = |((sl_flags & slie_reg) | (df_flags & dfie_reg)); // [RULE15]
        route_next.channel = mon_reg[2:0];
        // Zero channel selects nothing in either direction
        route_next.rx_enable = !mon_reg[larm_mon_top_bit] && (mon_reg[2:0] != 3'h0); // [RULE9] [RULE10]
        // Transmit monitoring withheld while that channel loops back
        route_next.tx_enable = mon_reg[larm_mon_top_bit] && (mon_reg[2:0] != 3'h0)
            && !analog_loopback[mon_reg[2:0]]; // [RULE11]
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= larm_rst_byte;
            rvalid_reg <= 1'b0;
            irq_reg <= 1'b0;
            busy_reg <= 1'b0;
            route_reg <= '0;
        end else if (clk_en) begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            irq_reg <= irq_next;
            busy_reg <= busy_next;
            route_reg <= route_next;
        end
    end

    assign host_rdata = rdata_reg;
    assign host_rvalid = rvalid_reg;
    assign irq = irq_reg;
    assign sw_reset_busy = busy_reg;
    assign mon_route = route_reg;
endmodule : larm_regs
